// file: prom_programmer.sv
// Purpose: Drives a 512x8 field PROM through a full program pass
// Assumes: Read-back data is synchronous; pin levels shifted outside
// Notes:   Image words come from the user port, one per address
//
// Behaviour
// - Address and data pins select word and pattern
// - Write is a program pulse with stable pins
// - Repeat until match, then five times as many pulses again; the code gives up and flags fail after 20 tries
// - Pins stable 40 us before pulse, through end
`timescale 1ns/1ps
`default_nettype none
module prom_programmer
#(
	parameter int SETUP_CYC = prom_prog_pkg::SETUP_CYC,
	parameter int PULSE_CYC = prom_prog_pkg::PULSE_CYC,
	parameter int GAP_CYC   = prom_prog_pkg::GAP_CYC,
	parameter int READ_CYC  = prom_prog_pkg::READ_CYC
)
(
	input  wire logic                              clk_i,
	input  wire logic                              reset_n_i,
	input  wire logic                              start_i,
	input  wire logic [prom_prog_pkg::DATA_W-1:0]  image_data_i,
	input  wire logic [prom_prog_pkg::DATA_W-1:0]  read_data_i,
	output var  logic [prom_prog_pkg::ADDR_W-1:0]  image_addr_o,
	output var  logic [prom_prog_pkg::ADDR_W-1:0]  prom_addr_o,
	output var  logic [prom_prog_pkg::DATA_W-1:0]  prom_data_o,
	output var  logic                              prog_pulse_o,
	output var  logic                              prog_mode_o,
	output var  logic                              power_saver_o,
	output var  logic                              busy_o,
	output var  logic                              done_o,
	output var  logic                              fail_o
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_q;
	logic rst_n_q;

	// Two stage release keeps the reset edge clean
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	typedef enum logic [2:0] {IDLE, FETCH, SETUP, PULSE, GAP, VERIFY, OVER, FINISH} state_t;

	localparam int AW = prom_prog_pkg::ADDR_W;
	localparam int DW = prom_prog_pkg::DATA_W;
	localparam int CW = prom_prog_pkg::CNT_W;
	localparam int TW = prom_prog_pkg::TRY_W;

	state_t        state_q, state_d;
	logic [AW-1:0] addr_q, addr_d;
	logic [DW-1:0] word_q, word_d;
	logic [DW-1:0] pins_q, pins_d;
	logic [TW-1:0] tries_q, tries_d;
	logic [TW+2:0] over_q, over_d;
	logic          pulse_q, pulse_d;
	logic          mode_q, mode_d;
	logic          saver_q, saver_d;
	logic          done_q, done_d;
	logic          fail_q, fail_d;
	logic          load;
	logic [CW-1:0] count;
	logic          expired;

	// Timing for setup, pulse, gap and read settle
	prom_delay #(.CNT_W(CW)) u_delay (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_q),
		.load_i  (load),
		.count_i (count),
		.done_o  (expired)
	);

	// Next state of the program walk
	always_comb
	begin
		state_d = state_q;
		addr_d  = addr_q;
		word_d  = word_q;
		pins_d  = pins_q;
		tries_d = tries_q;
		over_d  = over_q;
		pulse_d = 1'b0;
		mode_d  = mode_q;
		saver_d = saver_q;
		done_d  = done_q;
		fail_d  = fail_q;
		load    = 1'b0;
		count   = '0;
		case (state_q)
			IDLE:
			begin
				saver_d = 1'b1;
				if (start_i)
				begin
					addr_d  = '0;
					mode_d  = 1'b1;
					saver_d = 1'b0;
					done_d  = 1'b0;
					fail_d  = 1'b0;
					state_d = FETCH;
				end
			end
			FETCH:
			begin
				// One cycle for the image port to answer
				word_d  = image_data_i;
				tries_d = '0;
				state_d = SETUP;
				load    = 1'b1;
				count   = CW'(SETUP_CYC);
			end
			SETUP:
			begin
				pins_d = ~word_q;
				if (expired)
				begin
					pulse_d = 1'b1;
					state_d = PULSE;
					load    = 1'b1;
					count   = CW'(PULSE_CYC);
				end
			end
			PULSE:
			begin
				pulse_d = !expired;
				if (expired)
				begin
					// Pins held through the trailing gap; zero hold needed
					state_d = GAP;
					load    = 1'b1;
					count   = CW'(GAP_CYC);
				end
			end
			GAP:
			begin
				if (expired)
				begin
					if (over_q != '0)
					begin
						over_d  = over_q - 1'b1;
						state_d = over_q == {{(TW+2){1'b0}}, 1'b1} ? OVER : SETUP;
						load    = over_q != {{(TW+2){1'b0}}, 1'b1};
						count   = CW'(SETUP_CYC);
					end
					else
					begin
						tries_d = tries_q + 1'b1;
						state_d = VERIFY;
						load    = 1'b1;
						count   = CW'(READ_CYC);
					end
				end
			end
			VERIFY:
			begin
				if (expired)
				begin
					if (read_data_i == word_q)
					begin
						over_d  = (TW+3)'(prom_prog_pkg::OVER_MULT * int'(tries_q));
						state_d = SETUP;
						load    = 1'b1;
						count   = CW'(SETUP_CYC);
					end
					else if (tries_q >= TW'(prom_prog_pkg::MAX_TRIES))
					begin
						fail_d  = 1'b1;
						state_d = FINISH;
					end
					else
					begin
						state_d = SETUP;
						load    = 1'b1;
						count   = CW'(SETUP_CYC);
					end
				end
			end
			OVER:
			begin
				// Next address only after this word is finished
				if (addr_q == AW'(prom_prog_pkg::WORDS - 1))
				begin
					state_d = FINISH;
				end
				else
				begin
					addr_d  = addr_q + 1'b1;
					state_d = FETCH;
				end
			end
			FINISH:
			begin
				mode_d  = 1'b0;
				done_d  = 1'b1;
				state_d = IDLE;
			end
			default:
			begin
				state_d = IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			state_q <= IDLE;
			addr_q  <= '0;
			word_q  <= '0;
			pins_q  <= '1;
			tries_q <= '0;
			over_q  <= '0;
			pulse_q <= 1'b0;
			mode_q  <= 1'b0;
			saver_q <= 1'b1;
			done_q  <= 1'b0;
			fail_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			addr_q  <= addr_d;
			word_q  <= word_d;
			pins_q  <= pins_d;
			tries_q <= tries_d;
			over_q  <= over_d;
			pulse_q <= pulse_d;
			mode_q  <= mode_d;
			saver_q <= saver_d;
			done_q  <= done_d;
			fail_q  <= fail_d;
		end
	end

	// Pins come straight from flip-flops
	assign image_addr_o  = addr_q;
	assign prom_addr_o   = addr_q;
	assign prom_data_o   = pins_q;
	assign prog_pulse_o  = pulse_q;
	assign prog_mode_o   = mode_q;
	assign power_saver_o = saver_q;
	assign busy_o        = mode_q; // Mode flop tracks state_q != IDLE exactly
	assign done_o        = done_q;
	assign fail_o        = fail_q;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_pulse_rise;
		!pulse_q ##1 pulse_q;
	endsequence

	a_pins_stable: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		pulse_q |-> $stable(prom_addr_o) && $stable(prom_data_o))
		else $error("address or data moved during pulse");
	a_pulse_setup: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		s_pulse_rise |-> $past(state_q) == SETUP && $past(pins_q) == pins_q)
		else $error("pulse began without setup");
	a_data_invert: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		pulse_q |-> prom_data_o == ~word_q)
		else $error("data pins not inverted image");
	a_saver_idle: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		pulse_q |-> !power_saver_o)
		else $error("power saver on during pulse");
	a_addr_order: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		addr_q != $past(addr_q) && state_q != IDLE |-> addr_q == $past(addr_q) + 1'b1
		|| addr_q == '0)
		else $error("address skipped");
	a_over_count: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		state_q == VERIFY && expired && read_data_i == word_q
		|=> over_q == (TW+3)'(prom_prog_pkg::OVER_MULT * int'(tries_q)))
		else $error("overprogram count wrong");
	a_mode_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_q)
		pulse_q |-> prog_mode_o)
		else $error("pulse outside program mode");
endmodule : prom_programmer
`default_nettype wire

// file: prom_prog_pkg.sv
// Purpose: Shared constants for the PROM programming controller
// Assumes: 250 MHz system clock
// Notes:   Pin levels are logic levels; a level shifter drives the part
`default_nettype none
package prom_prog_pkg;
	// ****************************************
	// Geometry
	// ****************************************
	localparam int ADDR_W     = 9;
	localparam int DATA_W     = 8;
	localparam int WORDS      = 512;
	localparam int OVER_MULT  = 5;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ     = 250;
	localparam int SETUP_US    = 40;
	localparam int PULSE_US    = 1000;
	localparam int GAP_US      = 3000;
	localparam int READ_US     = 2;
	localparam int SETUP_CYC   = SETUP_US * CLK_MHZ;
	localparam int PULSE_CYC   = PULSE_US * CLK_MHZ;
	localparam int GAP_CYC     = GAP_US * CLK_MHZ;
	localparam int READ_CYC    = READ_US * CLK_MHZ;
	localparam int MAX_TRIES   = 20;
	localparam int TRY_W       = 8;
	localparam int CNT_W       = 20;
endpackage : prom_prog_pkg
`default_nettype wire

// file: prom_delay.sv
// Purpose: Loadable down counter that reports expiry
// Assumes: Synchronous inputs
// Notes:   done_o pulses one cycle when the count runs out
`timescale 1ns/1ps
`default_nettype none
module prom_delay
#(
	parameter int CNT_W = 20
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             load_i,
	input  wire logic [CNT_W-1:0] count_i,
	output var  logic             done_o
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             run_q;
	logic             run_d;
	logic             done_q;
	logic             done_d;

	// Next count; load wins over an expiring count
	always_comb
	begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		if (load_i)
		begin
			cnt_d = count_i;
			run_d = 1'b1;
		end
		else if (run_q)
		begin
			if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1})
			begin
				run_d  = 1'b0;
				done_d = 1'b1;
			end
			else
			begin
				cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// Registers
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
		end
	end

	assign done_o = done_q;
endmodule : prom_delay
`default_nettype wire

// file: prom_device_model.sv
// Purpose: Behavioural 512x8 field PROM seen from the programmer side
// Assumes: Pins are sampled on the system clock
// Notes:   One weak word needs two pulses; stuck_i makes every pulse fail
`timescale 1ns/1ps
`default_nettype none
module prom_device_model
#(
	parameter int SETUP_MIN = 4,
	parameter int WEAK_ADDR = 3
)
(
	input  wire logic       clk_i,
	input  wire logic [8:0] addr_i,
	input  wire logic [7:0] data_i,
	input  wire logic       pulse_i,
	input  wire logic       mode_i,
	input  wire logic       saver_i,
	input  wire logic       stuck_i,
	output var  logic [7:0] read_o
);
	logic [7:0]  mem [512];
	logic [1:0]  hits [512];
	logic [16:0] pins_q;
	logic        pulse_q;
	int          stable;
	int          pulses;
	int          faults;
	int          last;
	// ****************************************
	// Storage
	// ****************************************
	// Blank part holds zeros and nothing else
	initial
	begin
		for (int i = 0; i < 512; i++)
		begin
			mem[i] = 8'h00;
			hits[i] = 2'h0;
		end
		pins_q = 17'h00000;
		pulse_q = 1'b0;
		stable = 0;
		pulses = 0;
		faults = 0;
		last = 0;
	end
	// Idle part gives no valid data, so show the inverse
	assign read_o = (mode_i && !saver_i) ? mem[addr_i] : ~mem[addr_i];
	// ****************************************
	// Pin watch and write
	// ****************************************
	// Faults counted here rather than stopped, so the bench sees them all
	always @(posedge clk_i)
	begin
		stable <= ({addr_i, data_i} == pins_q) ? stable + 1 : 0;
		pins_q <= {addr_i, data_i};
		pulse_q <= pulse_i;
		if (!mode_i)
			last <= 0;
		if (pulse_i && !pulse_q)
		begin
			pulses <= pulses + 1;
			// Count lags the pins by one sample, hence the extra cycle
			if (stable + 1 < SETUP_MIN || !mode_i || int'(addr_i) < last)
				faults <= faults + 1;
			last <= int'(addr_i);
		end
		if (pulse_q && {addr_i, data_i} != pins_q)
			faults <= faults + 1;
		// Low data pin sets a one at the end of the pulse
		if (!pulse_i && pulse_q && !stuck_i)
		begin
			hits[addr_i] <= hits[addr_i] + 2'h1;
			if (addr_i != WEAK_ADDR || hits[addr_i] != 2'h0)
				mem[addr_i] <= mem[addr_i] | ~data_i;
		end
	end
endmodule : prom_device_model
`default_nettype wire

// file: prom_programming_sequence_tb.sv
// Purpose: Self-checking bench for the PROM programming controller
// Assumes: Short delay parameters keep a full pass near 75k cycles
// Notes:   Image word is address xor C3, so two words are all zeros
`timescale 1ns/1ps
`default_nettype none
module prom_programming_sequence_tb;
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       start = 1'b0;
	logic       stuck = 1'b0;
	logic [7:0] image_data;
	logic [7:0] read_data;
	logic [8:0] image_addr;
	logic [8:0] prom_addr;
	logic [7:0] prom_data;
	logic       prog_pulse;
	logic       prog_mode;
	logic       power_saver;
	logic       busy;
	logic       done;
	logic       fail;
	int         miscompares = 0;
	int         comparisons = 0;
	// ****************************************
	// Clock, image and instances
	// ****************************************
	// 250 MHz
	always #2 clk = ~clk;
	assign image_data = image_addr[7:0] ^ 8'hC3;
	prom_programmer #(.SETUP_CYC(4), .PULSE_CYC(4), .GAP_CYC(12), .READ_CYC(2)) i_dut (
		.clk_i(clk), .reset_n_i(reset_n), .start_i(start), .image_data_i(image_data),
		.read_data_i(read_data), .image_addr_o(image_addr), .prom_addr_o(prom_addr),
		.prom_data_o(prom_data), .prog_pulse_o(prog_pulse), .prog_mode_o(prog_mode),
		.power_saver_o(power_saver), .busy_o(busy), .done_o(done), .fail_o(fail));
	prom_device_model i_model (
		.clk_i(clk), .addr_i(prom_addr), .data_i(prom_data), .pulse_i(prog_pulse),
		.mode_i(prog_mode), .saver_i(power_saver), .stuck_i(stuck), .read_o(read_data));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : compare
	task automatic kick();
		@(negedge clk) start = 1'b1;
		@(negedge clk) start = 1'b0;
		compare("busy after start", 1, busy);
	endtask : kick
	// Bounded wait for the pass to end
	task automatic wait_idle(input int limit);
		int n = 0;
		while (busy !== 1'b0 && n < limit)
		begin
			@(negedge clk);
			n++;
		end
		compare("idle in time", 1, n < limit);
	endtask : wait_idle
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		compare("pulse idle", 0, prog_pulse);
		compare("mode idle", 0, prog_mode);
		compare("saver idle", 1, power_saver);
		compare("data idle", 32'hFF, prom_data);
		compare("done idle", 0, done);
		compare("fail idle", 0, fail);
	endtask : test_reset
	// Word that never takes: twenty tries, then fail
	task automatic test_stuck();
		int p0 = i_model.pulses;
		stuck = 1'b1;
		kick();
		compare("saver busy", 0, power_saver);
		wait_idle(3000);
		compare("fail flag", 1, fail);
		compare("stuck pulses", prom_prog_pkg::MAX_TRIES, i_model.pulses - p0);
		stuck = 1'b0;
	endtask : test_stuck
	// Full pass with a refused restart in mid-run
	task automatic test_pass();
		int p0 = i_model.pulses;
		kick();
		compare("fail cleared", 0, fail);
		repeat (2000) @(negedge clk);
		start = 1'b1;
		@(negedge clk) start = 1'b0;
		compare("mode in pass", 1, prog_mode);
		wait_idle(80000);
		compare("done flag", 1, done);
		compare("fail flag", 0, fail);
		compare("pass pulses", 6 * 512 + 6, i_model.pulses - p0);
		compare("pin faults", 0, i_model.faults);
		for (int a = 0; a < prom_prog_pkg::WORDS; a++)
			compare("word", a[7:0] ^ 8'hC3, i_model.mem[a]);
		// Saver comes back one cycle after the sequencer reaches idle
		@(negedge clk);
		compare("saver after", 1, power_saver);
	endtask : test_pass
	// ****************************************
	// Sequence, verdict and watchdog
	// ****************************************
	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	initial
	begin
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		test_reset();
		test_stuck();
		test_pass();
		results();
	end
	// Pass needs about 75k cycles
	initial
	begin
		repeat (90000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule : prom_programming_sequence_tb
`default_nettype wire
